/* cause_latch_pkg.sv */
// Purpose: shared constants and types for the interrupt cause latch
// Assumes: 20-bit register address space, 32-bit data
// Notes: offsets besides the cause register are local layout
package cause_latch_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int CAUSE_W = 7;

  // register offsets
  localparam logic [ADDR_W-1:0] CAUSE_OFFSET = 20'h000c0;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 20'h000d0;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 20'h000d8;
  localparam logic [ADDR_W-1:0] THRESH_OFFSET = 20'h000dc;

  // cause bit positions
  localparam int TX_DESC_WB_BIT = 0;
  localparam int TX_QUEUE_EMPTY_BIT = 1;
  localparam int LINK_CHANGE_BIT = 2;
  localparam int RX_SEQ_ERR_BIT = 3;
  localparam int RX_MIN_THRESH_BIT = 4;
  localparam int RESERVED_BIT = 5;
  localparam int RX_OVERRUN_BIT = 6;

  // control register fields
  localparam int CTRL_PHY_INT_BIT = 0;
  localparam int CTRL_SERIAL_BIT = 1;
  localparam int CTRL_LINK_BIT = 2;
  localparam int CTRL_DELAY_LSB = 16;
  localparam int DELAY_W = 16;
  localparam int COUNT_W = 16;

  // values after reset
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 7'h00;
  localparam logic [CAUSE_W-1:0] MASK_RESET = 7'h00;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0040;
  localparam logic [COUNT_W-1:0] THRESH_RESET = 16'h0008;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } reg_req_s;

  // receive delimiter symbols
  typedef enum logic [2:0] {
    SYM_IDLE = 3'h0,
    SYM_SOF = 3'h1,
    SYM_DATA = 3'h2,
    SYM_PAD = 3'h3,
    SYM_EOF = 3'h4,
    SYM_FILL = 3'h5
  } sym_e;

endpackage

/* tx_delay_timer.sv */
// Purpose: delays the transmit write-back event when the delay bit is set
// Assumes: delay value in clock cycles, zero gives expiry two cycles after the start
// Notes: a delayed event while running joins the pending one
`timescale 1ns/1ps
`default_nettype none
module tx_delay_timer
  import cause_latch_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // delayed request
  input wire logic start_i,
  input wire logic [DELAY_W-1:0] delay_i,
  // expiry
  output logic expire_o
);

  typedef struct packed {
    logic run;
    logic [DELAY_W-1:0] cnt;
    logic fire;
  } timer_s;

  timer_s st_q;
  timer_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.fire = 1'b0;
    if (st_q.run) begin
      if (st_q.cnt == '0) begin
        st_d.run = 1'b0;
        st_d.fire = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end else if (start_i) begin
      st_d.run = 1'b1;
      st_d.cnt = delay_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expire_o = st_q.fire;

endmodule
`default_nettype wire

/* rx_sequence_checker.sv */
// Purpose: checks receive delimiter order in ten-bit serial mode
// Assumes: one symbol per valid cycle
// Notes: after an error it waits for idle before checking again
`timescale 1ns/1ps
`default_nettype none
module rx_sequence_checker
  import cause_latch_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // symbol stream
  input wire logic enable_i,
  input wire logic sym_valid_i,
  input wire sym_e sym_i,
  // result
  output logic error_o
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SOF = 6'h02,
    ST_DATA = 6'h04,
    ST_PAD = 6'h08,
    ST_END = 6'h10,
    ST_BAD = 6'h20
  } seq_e;

  typedef struct packed {
    seq_e state;
    logic err;
  } seq_s;

  seq_s st_q;
  seq_s st_d;
  seq_e nxt;

  always_comb begin
    st_d = st_q;
    st_d.err = 1'b0;
    nxt = ST_BAD;
    case (st_q.state)
      ST_IDLE: nxt = (sym_i == SYM_IDLE) ? ST_IDLE : (sym_i == SYM_SOF) ? ST_SOF : ST_BAD;
      ST_SOF: nxt = (sym_i == SYM_DATA) ? ST_DATA : ST_BAD;
      ST_DATA: nxt = (sym_i == SYM_DATA) ? ST_DATA : (sym_i == SYM_PAD) ? ST_PAD :
                     (sym_i == SYM_EOF) ? ST_END : ST_BAD;
      ST_PAD: nxt = (sym_i == SYM_EOF) ? ST_END : ST_BAD;
      ST_END: nxt = (sym_i == SYM_FILL) ? ST_END : (sym_i == SYM_IDLE) ? ST_IDLE : ST_BAD;
      ST_BAD: nxt = (sym_i == SYM_IDLE) ? ST_IDLE : ST_BAD;
      default: nxt = ST_BAD;
    endcase
    if (!enable_i) begin
      st_d.state = ST_IDLE;
    end else if (sym_valid_i) begin
      st_d.state = nxt;
      st_d.err = (nxt == ST_BAD) && (st_q.state != ST_BAD);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '{state: ST_IDLE, err: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign error_o = st_q.err;

endmodule
`default_nettype wire

/* interrupt_cause_latch.sv */
// Purpose: latches controller interrupt causes and drives one host interrupt
// Assumes: single clock, register port with read data one cycle later
// Notes: events are single-cycle pulses from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module interrupt_cause_latch
  import cause_latch_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire reg_req_s reg_req_i,
  output logic [DATA_W-1:0] rdata_o,
  // transmit events
  input wire logic tx_desc_done_i,
  input wire logic report_status_bit_i,
  input wire logic delay_interrupt_bit_i,
  input wire logic tx_queue_empty_i,
  // link
  input wire logic link_up_pin_i,
  input wire logic link_up_int_i,
  // receive events
  input wire logic rx_sym_valid_i,
  input wire sym_e rx_sym_i,
  input wire logic [COUNT_W-1:0] rx_desc_count_i,
  input wire logic rx_overrun_i,
  // host interrupt
  output logic irq_o
);

  typedef struct packed {
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] mask;
    logic phy_int_mode;
    logic serial_mode;
    logic [DELAY_W-1:0] delay;
    logic [COUNT_W-1:0] thresh;
    logic [2:0] link_sync;
    logic link_filt;
    logic link_prev;
    logic [COUNT_W-1:0] count_prev;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } latch_s;

  latch_s st_q;
  latch_s st_d;

  logic delayed_expire;
  logic seq_error;
  logic delayed_start;
  logic [CAUSE_W-1:0] events;
  logic [CAUSE_W-1:0] clear;
  logic link_sel;
  logic hit_cause;
  logic hit_mask;
  logic hit_ctrl;
  logic hit_thresh;
  logic [DATA_W-1:0] ctrl_word;

  // delayed write-back path
  assign delayed_start = tx_desc_done_i & report_status_bit_i & delay_interrupt_bit_i;

  tx_delay_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(delayed_start),
    .delay_i(st_q.delay),
    .expire_o(delayed_expire)
  );

  // delimiter order check
  rx_sequence_checker u_seq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(st_q.serial_mode),
    .sym_valid_i(rx_sym_valid_i),
    .sym_i(rx_sym_i),
    .error_o(seq_error)
  );

  // address decode
  assign hit_cause = (reg_req_i.addr == CAUSE_OFFSET);
  assign hit_mask = (reg_req_i.addr == MASK_OFFSET);
  assign hit_ctrl = (reg_req_i.addr == CTRL_OFFSET);
  assign hit_thresh = (reg_req_i.addr == THRESH_OFFSET);

  // link source selection
  assign link_sel = st_q.phy_int_mode ? link_up_int_i : st_q.link_filt;

  // event vector
  always_comb begin
    events = '0;
    events[TX_DESC_WB_BIT] = (tx_desc_done_i & report_status_bit_i & ~delay_interrupt_bit_i)
                             | delayed_expire;
    events[TX_QUEUE_EMPTY_BIT] = tx_queue_empty_i;
    events[LINK_CHANGE_BIT] = (link_sel != st_q.link_prev);
    events[RX_SEQ_ERR_BIT] = seq_error;
    events[RX_MIN_THRESH_BIT] = (rx_desc_count_i <= st_q.thresh)
                                && (st_q.count_prev > st_q.thresh);
    events[RX_OVERRUN_BIT] = rx_overrun_i;
  end

  // clear vector from software
  always_comb begin
    clear = '0;
    if (reg_req_i.re && hit_cause) begin
      clear = '1;
    end else if (reg_req_i.we && hit_cause) begin
      clear = reg_req_i.wdata[CAUSE_W-1:0];
    end
  end

  // control readback
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_PHY_INT_BIT] = st_q.phy_int_mode;
    ctrl_word[CTRL_SERIAL_BIT] = st_q.serial_mode;
    ctrl_word[CTRL_LINK_BIT] = link_sel;
    ctrl_word[CTRL_DELAY_LSB +: DELAY_W] = st_q.delay;
  end

  // next state
  always_comb begin
    st_d = st_q;

    // cause flags: set wins over clear
    st_d.cause = (st_q.cause & ~clear) | events;
    st_d.cause[RESERVED_BIT] = 1'b0;

    // link filtering: change counts when second and third stages agree
    st_d.link_sync = {st_q.link_sync[1:0], link_up_pin_i};
    if (st_q.link_sync[1] == st_q.link_sync[2]) begin
      st_d.link_filt = st_q.link_sync[2];
    end
    st_d.link_prev = link_sel;

    // descriptor count history
    st_d.count_prev = rx_desc_count_i;

    // register writes
    if (reg_req_i.we) begin
      if (hit_mask) begin
        st_d.mask = reg_req_i.wdata[CAUSE_W-1:0];
        st_d.mask[RESERVED_BIT] = 1'b0;
      end
      if (hit_ctrl) begin
        st_d.phy_int_mode = reg_req_i.wdata[CTRL_PHY_INT_BIT];
        st_d.serial_mode = reg_req_i.wdata[CTRL_SERIAL_BIT];
        st_d.delay = reg_req_i.wdata[CTRL_DELAY_LSB +: DELAY_W];
      end
      if (hit_thresh) begin
        st_d.thresh = reg_req_i.wdata[COUNT_W-1:0];
      end
    end

    // register reads, data in the following cycle
    st_d.rdata = '0;
    if (reg_req_i.re) begin
      if (hit_cause) begin
        st_d.rdata[CAUSE_W-1:0] = st_q.cause;
      end else if (hit_mask) begin
        st_d.rdata[CAUSE_W-1:0] = st_q.mask;
      end else if (hit_ctrl) begin
        st_d.rdata = ctrl_word;
      end else if (hit_thresh) begin
        st_d.rdata[COUNT_W-1:0] = st_q.thresh;
      end
    end

    // host interrupt
    st_d.irq = |(st_d.cause & st_d.mask);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q.cause <= CAUSE_RESET;
      st_q.mask <= MASK_RESET;
      st_q.phy_int_mode <= 1'b0;
      st_q.serial_mode <= 1'b0;
      st_q.delay <= DELAY_RESET;
      st_q.thresh <= THRESH_RESET;
      st_q.link_sync <= SYNC_RESET;
      st_q.link_filt <= 1'b0;
      st_q.link_prev <= 1'b0;
      st_q.count_prev <= '0;
      st_q.rdata <= '0;
      st_q.irq <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign irq_o = st_q.irq;

endmodule
`default_nettype wire

/* interrupt_cause_latch_checker.sv */
// Purpose: port assertions for the cause latch
// Assumes: one clock, reset synchronous active low
// Notes: bound to every latch instance
`timescale 1ns/1ps
`default_nettype none
module interrupt_cause_latch_checker
  import cause_latch_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire reg_req_s reg_req_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic tx_desc_done_i,
  input wire logic report_status_bit_i,
  input wire logic delay_interrupt_bit_i,
  input wire logic tx_queue_empty_i,
  input wire logic rx_overrun_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic wr;
  assign rd = reg_req_i.re && reg_req_i.addr == CAUSE_OFFSET;
  assign wr = reg_req_i.we && reg_req_i.addr == CAUSE_OFFSET;
  sequence s_ovr_rd;
    rx_overrun_i ##1 rd;
  endsequence
  sequence s_ovr_keep_wr;
    rx_overrun_i ##1 (wr && !reg_req_i.wdata[6]) ##1 !(rd || wr) ##1 rd;
  endsequence
  sequence s_ovr_in_rd;
    rd && rx_overrun_i ##1 !(rd || wr) ##1 rd;
  endsequence
  sequence s_rd_quiet_rd;
    rd && !rx_overrun_i && !tx_queue_empty_i ##1 !rx_overrun_i && !tx_queue_empty_i ##1 rd;
  endsequence
  sequence s_wr_one_rd;
    wr && reg_req_i.wdata[6] && !rx_overrun_i ##1 !rx_overrun_i ##1 rd;
  endsequence
  a_rdata_idle: assert property (!reg_req_i.re |=> rdata_o == '0)
    else $error("read data outside read slot");
  a_reserved_zero: assert property (rd |=> rdata_o[31:7] == '0 && !rdata_o[5])
    else $error("reserved read bits set");
  a_overrun_set: assert property (s_ovr_rd |=> rdata_o[RX_OVERRUN_BIT])
    else $error("overrun flag missing");
  a_qempty_set: assert property (tx_queue_empty_i ##1 rd |=> rdata_o[TX_QUEUE_EMPTY_BIT])
    else $error("queue empty flag missing");
  a_wb_set: assert property (tx_desc_done_i && report_status_bit_i && !delay_interrupt_bit_i ##1 rd
    |=> rdata_o[TX_DESC_WB_BIT])
    else $error("write-back flag missing");
  a_event_kept: assert property (s_ovr_in_rd |=> rdata_o[6])
    else $error("event lost in clearing read");
  a_read_clears: assert property (s_rd_quiet_rd |=> !rdata_o[6] && !rdata_o[1])
    else $error("read did not clear");
  a_write_clears: assert property (s_wr_one_rd |=> !rdata_o[6])
    else $error("write one did not clear");
  a_write_zero_keeps: assert property (s_ovr_keep_wr |=> rdata_o[6])
    else $error("write zero cleared flag");
endmodule
bind interrupt_cause_latch interrupt_cause_latch_checker u_interrupt_cause_latch_checker (.clk_i, .rst_n_i,
  .reg_req_i, .rdata_o, .tx_desc_done_i, .report_status_bit_i, .delay_interrupt_bit_i, .tx_queue_empty_i,
  .rx_overrun_i);
`default_nettype wire

/* host_model.sv */
// Purpose: host software reaching the latch registers
// Assumes: tasks entered just after a rising edge, one idle cycle after each strobe
// Notes: each read notes its expected word in exp_fifo
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cause_latch_pkg::*;
(
  input wire logic clk_i,
  output var reg_req_s req_o
);
  logic [DATA_W-1:0] exp_fifo[$];
  initial req_o = '0;
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req_o <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    req_o.we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_fifo.push_back(e);
    req_o <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    req_o.re <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb_interrupt_cause_latch.sv */
// Purpose: self-checking bench for the cause latch
// Assumes: host model drives the register port
// Notes: reads are compared at the falling edge of their data cycle
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_cause_latch;
  import cause_latch_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  reg_req_s req;
  logic [DATA_W-1:0] rdata_o;
  logic irq_o;
  logic rd_seen = 1'b0;
  logic tx_done = 1'b0, rpt_bit = 1'b0, dly_bit = 1'b0, qe = 1'b0, ovr = 1'b0;
  logic lpin = 1'b0, lint = 1'b0, sv = 1'b0;
  sym_e sym = SYM_IDLE;
  logic [COUNT_W-1:0] cnt = 16'h0100;
  logic [6:0] m;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 5999;
  interrupt_cause_latch u_interrupt_cause_latch (.clk_i, .rst_n_i, .reg_req_i(req), .rdata_o,
    .tx_desc_done_i(tx_done), .report_status_bit_i(rpt_bit), .delay_interrupt_bit_i(dly_bit),
    .tx_queue_empty_i(qe), .link_up_pin_i(lpin), .link_up_int_i(lint), .rx_sym_valid_i(sv),
    .rx_sym_i(sym), .rx_desc_count_i(cnt), .rx_overrun_i(ovr), .irq_o);
  host_model u_host_model (.clk_i, .req_o(req));
  initial forever #25 clk_i = ~clk_i;
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    u_host_model.rd(a, e);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    u_host_model.wr(a, d);
  endtask
  task automatic ev(input logic [2:0] v);
    {tx_done, qe, ovr} <= v;
    tick(1);
    {tx_done, qe, ovr} <= 3'h0;
  endtask
  task automatic send(input logic [14:0] s);
    for (int i = 4; i >= 0; i--) begin
      sv <= 1'b1;
      sym <= sym_e'(s[i*3+:3]);
      tick(1);
    end
    sv <= 1'b0;
  endtask
  // read data compared in the cycle after each read strobe
  always @(negedge clk_i) begin
    if (rd_seen) check(rdata_o, u_host_model.exp_fifo.pop_front());
    rd_seen = req.re;
  end
  initial begin
    tick(2000);
    mismatches++;
    print_verdict();
  end
  initial begin
    tick(12);
    rst_n_i <= 1'b1;
    tick(1);
    rd(CAUSE_OFFSET, 32'h00000000);
    rd(MASK_OFFSET, 32'h00000000);
    rd(CTRL_OFFSET, 32'h00400000);
    rd(THRESH_OFFSET, 32'h00000008);
    rd(20'h000c4, 32'h00000000);
    $display("reset values done");
    ev(3'h4);
    rd(CAUSE_OFFSET, 32'h00000000);
    rpt_bit <= 1'b1;
    ev(3'h7);
    rd(CAUSE_OFFSET, 32'h00000043);
    rd(CAUSE_OFFSET, 32'h00000000);
    ev(3'h3);
    wr(CAUSE_OFFSET, 32'h00000002);
    rd(CAUSE_OFFSET, 32'h00000040);
    ev(3'h1);
    wr(CAUSE_OFFSET, 32'h00000040);
    rd(CAUSE_OFFSET, 32'h00000000);
    fork
      ev(3'h1);
      rd(CAUSE_OFFSET, 32'h00000000);
    join
    rd(CAUSE_OFFSET, 32'h00000040);
    $display("set and clear done");
    wr(CTRL_OFFSET, 32'h00020000);
    dly_bit <= 1'b1;
    ev(3'h4);
    dly_bit <= 1'b0;
    rd(CAUSE_OFFSET, 32'h00000000);
    tick(5);
    rd(CAUSE_OFFSET, 32'h00000001);
    $display("delayed write-back done");
    repeat (3) begin
      m = 7'($random(seed));
      wr(MASK_OFFSET, {25'h0, m});
      rd(MASK_OFFSET, {25'h0, m & 7'h5f});
      ev(3'h3);
      @(negedge clk_i);
      check({31'h0, irq_o}, {31'h0, |(m & 7'h42)});
      tick(1);
      rd(CAUSE_OFFSET, 32'h00000042);
      @(negedge clk_i);
      check({31'h0, irq_o}, 32'h00000000);
      tick(1);
    end
    $display("interrupt mask done");
    lpin <= 1'b1;
    tick(8);
    rd(CAUSE_OFFSET, 32'h00000004);
    lint <= 1'b1;
    wr(CTRL_OFFSET, 32'h00000001);
    tick(8);
    rd(CAUSE_OFFSET, 32'h00000000);
    lint <= 1'b0;
    tick(3);
    rd(CAUSE_OFFSET, 32'h00000004);
    $display("link change done");
    cnt <= 16'h0008;
    tick(3);
    rd(CAUSE_OFFSET, 32'h00000010);
    rd(CAUSE_OFFSET, 32'h00000000);
    wr(CTRL_OFFSET, 32'h00000003);
    send(15'h02a0);
    tick(3);
    rd(CAUSE_OFFSET, 32'h00000000);
    send(15'h0300);
    tick(3);
    rd(CAUSE_OFFSET, 32'h00000008);
    $display("threshold and sequence done");
    tick(2);
    print_verdict();
  end
endmodule
`default_nettype wire
